// ### bench/adc_result_sequencing_tb.sv
`default_nettype none
module adc_result_sequencing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in = 0, rst_in = 1, clk_en_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0, rd;
    logic err;
    wire logic pready_out, pslverr_out, scan_restart_out, sample_control_out;
    wire logic opamp2_enable_out, done_flag_out, dma_req_out, irq_out;
    wire logic conv_start_in, conv_done_in;
    wire logic [31:0] prdata_out;
    wire logic [11:0] conv_result_in;
    wire logic [4:0] scan_channel_in, scan_index_out;
    wire logic [15:0] analog_input_avail_out, dma_addr_out;
    int fails = 0, check_count = 0, restarts = 0, i, k;
    logic [5:0] rows [5] = '{6'h00, 6'h03, 6'h0F, 6'h21, 6'h12};
    logic [5:0] row;
    adc_result_sequencing dut_u (.sys_clk_in, .rst_in, .clk_en_in, .psel_in, .penable_in,
        .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .prdata_out, .pslverr_out,
        .conv_start_in, .conv_done_in, .conv_result_in, .scan_channel_in, .scan_index_out,
        .scan_restart_out, .sample_control_out, .opamp2_enable_out, .analog_input_avail_out,
        .done_flag_out, .dma_req_out, .dma_addr_out, .irq_out);
    conv_core_model core_u (.clk_in(sys_clk_in), .start_out(conv_start_in),
        .done_out(conv_done_in), .result_out(conv_result_in), .chan_out(scan_channel_in));
    always #4 sys_clk_in = ~sys_clk_in;
    always @(negedge sys_clk_in) if (scan_restart_out === 1'b1) restarts++;
    task automatic wrap_up;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // Called just after an edge; ends one idle edge later so effects have landed
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        // Sample mid-cycle, where the answer stands before the taking edge
        for (n = 0; n < 16; n++) begin
            @(negedge sys_clk_in);
            if (pready_out === 1'b1) break;
            @(posedge sys_clk_in);
        end
        if (n == 16) begin
            fails++;
            wrap_up;
        end
        rd = prdata_out;
        err = pslverr_out;
        @(posedge sys_clk_in);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    initial begin
        repeat (16) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        foreach (rows[r]) begin
            row = rows[r];
            apb(1'b1, 12'h000, {26'h0, row});
            apb(1'b1, 12'h008, 32'h7);
            apb(1'b1, 12'h00C, 32'h1);
            k = restarts;
            for (i = 0; i <= row[3:0]; i++) begin
                chk(irq_out, 0, "irq early");
                core_u.run({row, i[5:0]}, i[4:0]);
                if (row[5]) begin
                    apb(1'b0, 12'h040, 32'h0);
                    chk(rd, {row, i[5:0]}, "dma buffer");
                end
            end
            chk(irq_out, 1, "irq at count");
            for (i = 0; i <= row[3:0] && !row[5]; i++) begin
                apb(1'b0, 12'h040 + 12'(4 * i), 32'h0);
                chk(rd, {row, i[5:0]}, "buffer order");
            end
            if (row[4]) chk(restarts, k + 1, "scan restart");
            if (row[4]) chk(scan_index_out, 0, "scan first entry");
        end
        apb(1'b0, 12'h020, 32'h0);
        chk(err, 1, "unmapped err");
        chk(rd, 0, "unmapped data");
        apb(1'b1, 12'h00C, 32'h0);
        chk(irq_out, 0, "masked irq");
        apb(1'b1, 12'h00C, 32'h1);
        chk(irq_out, 1, "unmasked irq");
        apb(1'b1, 12'h008, 32'h1);
        chk(irq_out, 0, "cleared irq");
        chk(done_flag_out, 1, "done held");
        apb(1'b1, 12'h000, 32'h100);
        chk(done_flag_out, 0, "done soft clear");
        apb(1'b1, 12'h000, 32'hC0);
        chk(sample_control_out, 1, "sample bit");
        chk(analog_input_avail_out, 32'hFFF8, "op amp inputs");
        core_u.run(12'hA5C, 5'h03);
        chk(done_flag_out, 1, "done set");
        rst_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        chk(done_flag_out, 0, "reset done");
        apb(1'b1, 12'h000, 32'h20);
        for (i = 1; i <= 32; i++) begin
            core_u.run(i[11:0], 5'h00);
            chk(dma_addr_out, 32'(i / 32), "dma step");
        end
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 1, "dma addr reg");
        wrap_up;
    end
endmodule // adc_result_sequencing_tb
`default_nettype wire

// ### bench/adc_seq_properties.sv
`default_nettype none
module adc_seq_checker (
    input wire logic sys_clk_in, // Clock
    input wire logic rst_in, // Reset
    input wire logic clk_en_in, // Run
    input wire logic psel_in, // Select
    input wire logic penable_in, // Enable
    input wire logic pwrite_in, // Write
    input wire logic conv_start_in, // Start
    input wire logic conv_done_in, // Done
    input wire logic scan_restart_out, // Restart
    input wire logic opamp2_enable_out, // Op amp
    input wire logic [15:0] analog_input_avail_out, // Inputs
    input wire logic done_flag_out, // Flag
    input wire logic dma_req_out, // DMA req
    input wire logic [15:0] dma_addr_out, // DMA addr
    input wire logic irq_out // Irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    wire logic wr = psel_in & penable_in & pwrite_in;
    wire logic cd = conv_done_in & clk_en_in;
    AST_DONE_SET: assert property (cd |=> done_flag_out)
        else $error("done flag not set");
    AST_DONE_CLR: assert property ($fell(done_flag_out) |-> $past(conv_start_in | wr))
        else $error("done flag dropped alone");
    AST_DONE_RISE: assert property ($rose(done_flag_out) |-> $past(cd))
        else $error("done flag rose alone");
    AST_AVAIL: assert property (analog_input_avail_out == (opamp2_enable_out ? 16'hFFF8 : 16'hFFFF))
        else $error("input availability wrong");
    AST_DMA_REQ: assert property (dma_req_out |-> $past(cd))
        else $error("dma request without result");
    AST_DMA_ADDR: assert property ($changed(dma_addr_out) |-> $past(cd | wr))
        else $error("dma address moved alone");
    AST_IRQ: assert property ($rose(irq_out) |-> $past(cd | wr))
        else $error("irq rose alone");
    AST_SCAN: assert property (scan_restart_out |-> $past(cd))
        else $error("scan restart without result");
    cover property ($rose(irq_out));
    cover property (dma_req_out);
    cover property (scan_restart_out);
endmodule // adc_seq_checker
bind adc_result_sequencing adc_seq_checker chk_u (.sys_clk_in, .rst_in, .clk_en_in,
    .psel_in, .penable_in, .pwrite_in, .conv_start_in, .conv_done_in, .scan_restart_out,
    .opamp2_enable_out, .analog_input_avail_out, .done_flag_out, .dma_req_out,
    .dma_addr_out, .irq_out);
`default_nettype wire

// ### bench/conv_core_model.sv
`default_nettype none
module conv_core_model (
    input wire logic clk_in, // Clock
    output logic start_out, // Start pulse
    output logic done_out, // Done pulse
    output logic [11:0] result_out, // Result
    output logic [4:0] chan_out // Channel
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        start_out = 1'b0;
        done_out = 1'b0;
        result_out = 12'hFFF;
        chan_out = 5'h1F;
    end
    task automatic run(input logic [11:0] r, input logic [4:0] c);
        @(posedge clk_in) start_out <= 1'b1;
        @(posedge clk_in) start_out <= 1'b0;
        @(posedge clk_in) done_out <= 1'b1;
        result_out <= r;
        chan_out <= c;
        @(posedge clk_in) done_out <= 1'b0;
        // Stale result must not look valid
        result_out <= ~r;
        chan_out <= ~c;
        @(posedge clk_in);
    endtask
endmodule // conv_core_model
`default_nettype wire

// ### logic/adc_result_sequencing.v
// The register addresses and the APB slave port were chosen for this implementation.
`include "adc_seq_defines.vh"
`default_nettype none
module adc_result_sequencing (
    input wire sys_clk_in, // 125 MHz clock
    input wire rst_in, // Async reset, active high
    input wire clk_en_in, // Freezes state when low
    input wire psel_in, // APB select
    input wire penable_in, // APB enable
    input wire pwrite_in, // APB direction
    input wire [11:0] paddr_in, // APB byte address
    input wire [31:0] pwdata_in, // APB write data
    output wire pready_out, // APB ready
    output reg [31:0] prdata_out, // APB read data
    output wire pslverr_out, // APB error
    input wire conv_start_in, // Core: conversion starts
    input wire conv_done_in, // Core: conversion complete
    input wire [11:0] conv_result_in, // Core: result with done
    input wire [4:0] scan_channel_in, // Core: channel just converted
    output reg [4:0] scan_index_out, // Next scan list entry
    output reg scan_restart_out, // Scan list restarted pulse
    output wire sample_control_out, // Manual sample request
    output wire opamp2_enable_out, // Second op amp on
    output wire [15:0] analog_input_avail_out, // Inputs usable by converter
    output reg done_flag_out, // Conversion-done flag
    output reg dma_req_out, // Result ready for DMA pulse
    output reg [15:0] dma_addr_out, // DMA address pointer
    output wire irq_out // Level interrupt
);
    reg [8:0] ctrl;
    reg [31:0] scan_sel;
    reg [2:0] status;
    reg [2:0] int_mask;
    reg [3:0] buf_ptr;
    reg [3:0] smpi_cnt;
    reg [5:0] dma_cnt;
    reg [11:0] first_result_buffer;
    reg rd_pending;
    wire [11:0] mem_rd_data;

    wire [3:0] samples_per_interrupt = ctrl[`CTRL_SMPI_LSB +: 4];
    wire channel_scan_enable = ctrl[`CTRL_SCAN_EN];
    wire dma_mode_enable = ctrl[`CTRL_DMA_EN];

    wire apb_setup = psel_in & ~penable_in;
    wire apb_access = psel_in & penable_in;
    wire apb_wr = apb_access & pwrite_in;
    wire is_buf = (paddr_in >= `OFS_BUF_BASE) && (paddr_in <= `OFS_BUF_LAST);
    wire [3:0] buf_rd_idx = paddr_in[5:2];

    function reg_hit;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            reg_hit = (addr == ofs);
        end
    endfunction

    function mapped;
        input [11:0] addr;
        begin
            mapped = reg_hit(addr, `OFS_CTRL) | reg_hit(addr, `OFS_SCAN_SEL)
                | reg_hit(addr, `OFS_STATUS) | reg_hit(addr, `OFS_INT_MASK)
                | reg_hit(addr, `OFS_POINTERS) | reg_hit(addr, `OFS_DMA_ADDR)
                | ((addr >= `OFS_BUF_BASE) && (addr <= `OFS_BUF_LAST) && (addr[1:0] == 2'b00));
        end
    endfunction

    // Buffer reads wait one cycle for the registered memory output
    // Memory output is loaded at the setup edge, so it stands in the first access cycle
    wire buf_wait = is_buf & apb_access & ~rd_pending;
    assign pready_out = ~(is_buf & apb_access & ~rd_pending);
    assign pslverr_out = apb_access & pready_out & ~mapped(paddr_in);

    // Next scan entry: lowest selected channel above the current one
    function [4:0] next_sel;
        input [31:0] sel;
        input [4:0] cur;
        integer i;
        reg found;
        begin
            next_sel = cur;
            found = 1'b0;
            for (i = 31; i >= 0; i = i - 1) begin
                if (sel[i] && (i > cur)) begin
                    next_sel = i[4:0];
                    found = 1'b1;
                end
            end
            if (!found) begin
                next_sel = first_sel(sel);
            end
        end
    endfunction

    function [4:0] first_sel;
        input [31:0] sel;
        integer i;
        begin
            first_sel = 5'h00;
            for (i = 31; i >= 0; i = i - 1) begin
                if (sel[i]) begin
                    first_sel = i[4:0];
                end
            end
        end
    endfunction

    wire smpi_hit = (smpi_cnt == samples_per_interrupt);
    wire dma_step = dma_mode_enable && (dma_cnt == (`DMA_STEP_COUNT - 6'h01));

    // Write to the memory only outside DMA mode; DMA mode uses one register
    result_buffer_mem u_mem (
        .sys_clk_in(sys_clk_in),
        .clk_en_in(clk_en_in),
        .wr_en_in(conv_done_in & ~dma_mode_enable),
        .wr_addr_in(buf_ptr),
        .wr_data_in(conv_result_in),
        .rd_addr_in(buf_rd_idx),
        .rd_data_out(mem_rd_data)
    );

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_pending <= 1'b0;
        end else if (clk_en_in) begin
            rd_pending <= is_buf & apb_access & ~rd_pending;
        end
    end

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl <= `CTRL_RESET;
            scan_sel <= 32'h0000_0000;
            int_mask <= 3'h0;
        end else if (clk_en_in) begin
            if (apb_wr && reg_hit(paddr_in, `OFS_CTRL)) begin
                ctrl <= pwdata_in[8:0];
            end
            if (apb_wr && reg_hit(paddr_in, `OFS_SCAN_SEL)) begin
                scan_sel <= pwdata_in;
            end
            if (apb_wr && reg_hit(paddr_in, `OFS_INT_MASK)) begin
                int_mask <= pwdata_in[2:0];
            end
        end
    end

    // Counting, pointers and flags
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            buf_ptr <= 4'h0;
            smpi_cnt <= 4'h0;
            dma_cnt <= 6'h00;
            dma_addr_out <= 16'h0000;
            first_result_buffer <= 12'h000;
            scan_index_out <= 5'h00;
            scan_restart_out <= 1'b0;
            done_flag_out <= 1'b0;
            dma_req_out <= 1'b0;
            status <= 3'h0;
        end else if (clk_en_in) begin
            scan_restart_out <= 1'b0;
            dma_req_out <= 1'b0;
            // Software clear of done, as advised before manual sampling
            if (apb_wr && reg_hit(paddr_in, `OFS_CTRL) && pwdata_in[`CTRL_DONE_CLR]) begin
                done_flag_out <= 1'b0;
            end
            if (conv_start_in) begin
                done_flag_out <= 1'b0;
            end
            if (apb_wr && reg_hit(paddr_in, `OFS_STATUS)) begin
                status <= status & ~pwdata_in[2:0];
            end
            if (conv_done_in) begin
                done_flag_out <= 1'b1;
                status[`ST_DONE_EVENT] <= 1'b1;
                if (smpi_hit) begin
                    smpi_cnt <= 4'h0;
                    status[`ST_SMPI_EVENT] <= 1'b1;
                end else begin
                    smpi_cnt <= smpi_cnt + 4'h1;
                end
                if (dma_mode_enable) begin
                    first_result_buffer <= conv_result_in;
                    buf_ptr <= 4'h0;
                    dma_req_out <= 1'b1;
                    dma_cnt <= dma_step ? 6'h00 : dma_cnt + 6'h01;
                    if (dma_step) begin
                        dma_addr_out <= dma_addr_out + 16'h0001;
                        status[`ST_DMA_EVENT] <= 1'b1;
                    end
                end else begin
                    buf_ptr <= smpi_hit ? 4'h0 : buf_ptr + 4'h1;
                end
                if (channel_scan_enable) begin
                    if (smpi_hit) begin
                        scan_index_out <= first_sel(scan_sel);
                        scan_restart_out <= 1'b1;
                    end else begin
                        scan_index_out <= next_sel(scan_sel, scan_channel_in);
                    end
                end
            end
        end
    end

    assign irq_out = |(status & int_mask);
    assign sample_control_out = ctrl[`CTRL_SAMPLE];
    assign opamp2_enable_out = ctrl[`CTRL_OPAMP2_EN];
    // Op amp 2 owns inputs 0..2 while enabled
    assign analog_input_avail_out = opamp2_enable_out ? 16'hFFF8 : 16'hFFFF;

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (clk_en_in && (apb_setup | buf_wait)) begin
            // Load in the wait cycle so the word stands when pready is high
            if (buf_wait) begin
                prdata_out <= (dma_mode_enable && buf_rd_idx == 4'h0)
                    ? {20'h00000, first_result_buffer} : {20'h00000, mem_rd_data};
            end else if (reg_hit(paddr_in, `OFS_CTRL)) begin
                prdata_out <= {23'h000000, done_flag_out, ctrl[7:0]};
            end else if (reg_hit(paddr_in, `OFS_SCAN_SEL)) begin
                prdata_out <= scan_sel;
            end else if (reg_hit(paddr_in, `OFS_STATUS)) begin
                prdata_out <= {29'h00000000, status};
            end else if (reg_hit(paddr_in, `OFS_INT_MASK)) begin
                prdata_out <= {29'h00000000, int_mask};
            end else if (reg_hit(paddr_in, `OFS_POINTERS)) begin
                prdata_out <= {18'h00000, dma_cnt, smpi_cnt, buf_ptr};
            end else if (reg_hit(paddr_in, `OFS_DMA_ADDR)) begin
                prdata_out <= {16'h0000, dma_addr_out};
            end else begin
                prdata_out <= 32'h0000_0000;
            end
        end
    end
endmodule // adc_result_sequencing
`default_nettype wire

// ### logic/adc_seq_defines.vh
// Function
// - The samples_per_interrupt field sets after how many completed conversions the interrupt flag rises and an enabled interrupt is raised.
// - With channel_scan_enable set, the scan list restarts from its first entry at the samples_per_interrupt point.
// - With dma_mode_enable clear, the result write pointer returns to the first buffer at the samples_per_interrupt point.
// - With dma_mode_enable set, the DMA address pointer advances after each 32nd completed conversion.
// - With dma_mode_enable set, every result is written only into the first result buffer.
// - With dma_mode_enable clear, sixteen result buffers hold conversion results.
// - Without DMA, results fill consecutive buffers in completion order whatever channel produced them.
// - The conversion-done flag clears at a conversion start or a software write of the done-clear bit and sets at completion, staying set until then.
// - With the second op amp enabled, analog inputs zero to two are taken over and unusable as converter inputs.
`ifndef ADC_SEQ_DEFINES_VH
`define ADC_SEQ_DEFINES_VH
`define OFS_CTRL 12'h000
`define OFS_SCAN_SEL 12'h004
`define OFS_STATUS 12'h008
`define OFS_INT_MASK 12'h00C
`define OFS_POINTERS 12'h010
`define OFS_DMA_ADDR 12'h014
`define OFS_BUF_BASE 12'h040
`define OFS_BUF_LAST 12'h07C
`define CTRL_SMPI_LSB 0
`define CTRL_SCAN_EN 4
`define CTRL_DMA_EN 5
`define CTRL_OPAMP2_EN 6
`define CTRL_SAMPLE 7
`define CTRL_DONE_CLR 8
`define ST_SMPI_EVENT 0
`define ST_DONE_EVENT 1
`define ST_DMA_EVENT 2
`define CTRL_RESET 9'h000
`define DMA_STEP_COUNT 6'h20
`define RESULT_W 12
`define NUM_BUFS 16
`endif

// ### logic/result_buffer_mem.v
`default_nettype none
module result_buffer_mem (
    input wire sys_clk_in, // Clock
    input wire clk_en_in, // Clock enable
    input wire wr_en_in, // Write strobe
    input wire [3:0] wr_addr_in, // Write index
    input wire [11:0] wr_data_in, // Write data
    input wire [3:0] rd_addr_in, // Read index
    output reg [11:0] rd_data_out // Registered read data
);
    reg [11:0] mem [0:15];
    always @(posedge sys_clk_in) begin
        if (clk_en_in) begin
            if (wr_en_in) begin
                mem[wr_addr_in] <= wr_data_in;
            end
            rd_data_out <= mem[rd_addr_in];
        end
    end
endmodule // result_buffer_mem
`default_nettype wire
